/* File: core/ttrm_pkg.sv */
// Package for the trail trace receive monitor: register map, field layout, counts and carriers.
// Assumes a 16-bit register view placed in the low bits of a 32-bit classic Wishbone bus.
package ttrm_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] TTRM_IDX_CTRL    = 8'hf0;
   localparam logic [7:0] TTRM_IDX_PTR     = 8'hf2;
   localparam logic [7:0] TTRM_IDX_LIVE    = 8'hf4;
   localparam logic [7:0] TTRM_IDX_LATCH   = 8'hf6;
   localparam logic [7:0] TTRM_IDX_IRQ_EN  = 8'hf8;
   localparam logic [7:0] TTRM_IDX_PORT_EN = 8'hec;
   localparam logic [7:0] TTRM_IDX_RX_DATA = 8'hfc;
   localparam logic [7:0] TTRM_IDX_EX_DATA = 8'hfe;

   // Control register fields
   localparam int TTRM_CTRL_ALIGN_OFF  = 3;
   localparam int TTRM_CTRL_CMP_EN     = 2;
   localparam int TTRM_CTRL_W          = 4;

   // Pointer register fields
   localparam int TTRM_PTR_RX_LSB      = 0;
   localparam int TTRM_PTR_EX_LSB      = 8;

   // Event bits, shared by live, latch and enable registers
   localparam int TTRM_EV_IDLE         = 0;
   localparam int TTRM_EV_UNSTABLE     = 1;
   localparam int TTRM_EV_MISMATCH     = 2;
   localparam int TTRM_EV_CHANGE       = 3;
   localparam int TTRM_EV_N            = 4;
   // Bits latched on a rising live level; the rest latch a pulse
   localparam logic [3:0] TTRM_EV_EDGE_MASK = 4'h7;

   // Identifier shape and declaration counts
   localparam int TTRM_ID_BYTES        = 16;
   localparam int TTRM_PTR_W           = 4;
   localparam logic [3:0] TTRM_UNSTABLE_CNT = 4'h8;
   localparam logic [2:0] TTRM_IDLE_CNT     = 3'h5;

   // Reset values
   localparam logic [15:0] TTRM_RST_REG16 = 16'h0000;
   localparam logic [7:0]  TTRM_RST_BYTE  = 8'h00;

   // One trail trace byte from the receive framer
   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } ttrm_byte_s;

endpackage : ttrm_pkg

/* File: core/ttrm_assembler.sv */
// Gathers received trail trace bytes into one 16-byte identifier.
// Assumes the framer marks byte 0 with first unless alignment is switched off.
`timescale 1ns/1ps
`default_nettype none
module ttrm_assembler #(
   parameter int NBYTES = 16
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // Byte stream and control
   input  wire ttrm_pkg::ttrm_byte_s   in_byte,
   input  wire logic                   align_off,
   // Completed identifier
   output logic [NBYTES*8-1:0]         id_q,
   output logic                        done_q
);
   import ttrm_pkg::*;

   localparam int CW = $clog2(NBYTES);
   localparam logic [CW-1:0] LAST = CW'(NBYTES - 1);

   logic [7:0]    buf_q [NBYTES];
   logic [CW-1:0] cnt_q;
   logic          act_q;

   // Aligned mode waits for the first byte; unaligned starts anywhere
   wire           take = in_byte.valid && (align_off || in_byte.first || act_q);
   wire [CW-1:0]  slot = (in_byte.first && !align_off) ? '0 : cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q  <= '0;
         act_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= take && (slot == LAST);
         if (take) begin
            cnt_q <= slot + CW'(1);
            act_q <= (slot != LAST);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NBYTES; g++) begin : g_byte
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               buf_q[g] <= TTRM_RST_BYTE;
            end else if (take && slot == CW'(g)) begin
               buf_q[g] <= in_byte.data;
            end
         end
         // Byte 0 sits in the low lane
         assign id_q[g*8 +: 8] = buf_q[g];
      end
   endgenerate

endmodule : ttrm_assembler
`default_nettype wire

/* File: core/ttrm_event_latch.sv */
// Sticky event flags, write-one-to-clear, with set taking priority over clear.
// Flags chosen by EDGE_MASK latch on a rising source level, the others on a pulse.
`timescale 1ns/1ps
`default_nettype none
module ttrm_event_latch #(
   parameter int           N         = 4,
   parameter logic [N-1:0] EDGE_MASK = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Sources and software clear
   input  wire logic [N-1:0] src,
   input  wire logic [N-1:0] clr,
   // Sticky flags
   output logic [N-1:0]      flag_q
);
   import ttrm_pkg::*;

   logic [N-1:0] src_q;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         wire set = EDGE_MASK[g] ? (src[g] && !src_q[g]) : src[g];
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               src_q[g]  <= 1'b0;
               flag_q[g] <= 1'b0;
            end else begin
               src_q[g] <= src[g];
               if (set) begin
                  flag_q[g] <= 1'b1;
               end else if (clr[g]) begin
                  flag_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

endmodule : ttrm_event_latch
`default_nettype wire

/* File: core/ttrm_top.sv */
// Trail trace receive monitor: identifier capture, mismatch, unstable and idle detection,
// latched events with interrupt, and pointer-advancing identifier access over Wishbone.
// Assumes trail trace bytes arrive synchronous to clk from the receive framer.
//
// Summary of operation
// - Live mismatch bit is high while received and expected identifiers differ.
// - Unstable declared after eight identifiers matching neither last received nor stored.
// - Idle declared after five consecutive all-zero identifiers.
// - Change flag latches whenever the stored received identifier takes a new value.
// - Mismatch, unstable and idle flags latch only on a rising live bit.
// - Interrupt needs a set flag, its enable, and this port's global enable.
// - Received data read returns byte at pointer, pointer advances, wraps fh to 0h.
// - Expected data read or write uses byte at pointer, advances, wraps fh to 0h.
// - Live idle and unstable bits drop once their condition stops holding.
// - Comparison runs only with compare enable set and alignment not disabled.
// - Both pointers are 4-bit fields naming the next byte, 0h is first.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ttrm_top #(
   parameter int ADR_W  = 12,
   parameter int NBYTES = 16
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   // Receive framer byte stream
   input  wire ttrm_pkg::ttrm_byte_s rx_byte,
   // Interrupt
   output logic                      irq
);
   import ttrm_pkg::*;

   localparam int IDW = NBYTES * 8;

   // Bus decode
   wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wr       = req && wb_we_i;
   wire        rd       = req && !wb_we_i;
   wire [7:0]  idx      = wb_adr_i[9:2];
   wire        hi_zero  = (wb_adr_i[ADR_W-1:10] == '0);
   wire        sel_lo   = wb_sel_i[0];
   wire        sel_hi   = wb_sel_i[1];
   wire        hit_ctrl = hi_zero && idx == TTRM_IDX_CTRL;
   wire        hit_ptr  = hi_zero && idx == TTRM_IDX_PTR;
   wire        hit_live = hi_zero && idx == TTRM_IDX_LIVE;
   wire        hit_lat  = hi_zero && idx == TTRM_IDX_LATCH;
   wire        hit_ien  = hi_zero && idx == TTRM_IDX_IRQ_EN;
   wire        hit_pen  = hi_zero && idx == TTRM_IDX_PORT_EN;
   wire        hit_rxd  = hi_zero && idx == TTRM_IDX_RX_DATA;
   wire        hit_exd  = hi_zero && idx == TTRM_IDX_EX_DATA;

   // Software state
   logic [TTRM_CTRL_W-1:0] ctrl_q;
   logic [TTRM_PTR_W-1:0]  rx_ptr_q;
   logic [TTRM_PTR_W-1:0]  ex_ptr_q;
   logic [TTRM_EV_N-1:0]   irq_en_q;
   logic                   port_en_q;
   logic [7:0]             exp_q [NBYTES];
   logic [IDW-1:0]         exp_flat;

   wire align_off = ctrl_q[TTRM_CTRL_ALIGN_OFF];
   wire cmp_en    = ctrl_q[TTRM_CTRL_CMP_EN];

   // Identifier capture
   logic [IDW-1:0] id_new;
   logic           id_done;

   ttrm_assembler #(
      .NBYTES (NBYTES)
   ) u_asm (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_byte   (rx_byte),
      .align_off (align_off),
      .id_q      (id_new),
      .done_q    (id_done)
   );

   // Identifier history and condition counters
   logic [IDW-1:0] prev_q;
   logic [IDW-1:0] cur_q;
   logic [3:0]     unst_cnt_q;
   logic [2:0]     idle_cnt_q;
   logic           change_q;
   logic           mism_q;

   wire same_prev = (id_new == prev_q);
   wire same_cur  = (id_new == cur_q);
   wire all_zero  = (id_new == '0);
   // A repeated identifier that differs from the stored one replaces it
   wire accept    = id_done && same_prev && !same_cur;
   // Run counters restart on any identifier that breaks the run
   wire unst_brk  = id_done && (same_prev || same_cur);
   wire unst_step = id_done && (unst_cnt_q != TTRM_UNSTABLE_CNT);
   wire idle_brk  = id_done && !all_zero;
   wire idle_step = id_done && (idle_cnt_q != TTRM_IDLE_CNT);

   // Last received and stored identifiers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_q   <= '0;
         cur_q    <= '0;
         change_q <= 1'b0;
      end else begin
         change_q <= accept;
         if (id_done) begin
            prev_q <= id_new;
         end
         if (accept) begin
            cur_q <= id_new;
         end
      end
   end

   // Unstable run: identifiers matching neither the last nor the stored one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         unst_cnt_q <= '0;
      end else if (unst_brk) begin
         unst_cnt_q <= '0;
      end else if (unst_step) begin
         unst_cnt_q <= unst_cnt_q + 4'h1;
      end
   end

   // Idle run: consecutive all-zero identifiers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idle_cnt_q <= '0;
      end else if (idle_brk) begin
         idle_cnt_q <= '0;
      end else if (idle_step) begin
         idle_cnt_q <= idle_cnt_q + 3'h1;
      end
   end

   // Live conditions follow the present state only
   wire live_unst = (unst_cnt_q == TTRM_UNSTABLE_CNT);
   wire live_idle = (idle_cnt_q == TTRM_IDLE_CNT);
   wire cmp_on    = cmp_en && !align_off;

   // Registered: mismatch follows a stored or expected change one cycle later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mism_q <= 1'b0;
      end else begin
         mism_q <= cmp_on && (cur_q != exp_flat);
      end
   end

   logic [TTRM_EV_N-1:0] live;
   always_comb begin
      live                   = '0;
      live[TTRM_EV_IDLE]     = live_idle;
      live[TTRM_EV_UNSTABLE] = live_unst;
      live[TTRM_EV_MISMATCH] = mism_q;
      live[TTRM_EV_CHANGE]   = change_q;
   end

   // Sticky events
   wire [TTRM_EV_N-1:0] lat_clr = (wr && hit_lat && sel_lo) ? wb_dat_i[TTRM_EV_N-1:0] : '0;
   logic [TTRM_EV_N-1:0] latch_q;

   ttrm_event_latch #(
      .N         (TTRM_EV_N),
      .EDGE_MASK (TTRM_EV_EDGE_MASK)
   ) u_lat (
      .clk     (clk),
      .sys_rst (sys_rst),
      .src     (live),
      .clr     (lat_clr),
      .flag_q  (latch_q)
   );

   // Identifier byte access
   wire rx_step  = rd && hit_rxd;
   // A write without the low byte lane leaves the expected pointer alone
   wire ex_step  = hit_exd && req && (!wb_we_i || sel_lo);
   wire ptr_wr   = wr && hit_ptr;

   genvar g;
   generate
      for (g = 0; g < NBYTES; g++) begin : g_exp
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               exp_q[g] <= TTRM_RST_BYTE;
            end else if (wr && hit_exd && sel_lo && ex_ptr_q == TTRM_PTR_W'(g)) begin
               exp_q[g] <= wb_dat_i[7:0];
            end
         end
         assign exp_flat[g*8 +: 8] = exp_q[g];
      end
   endgenerate

   // Pointers wrap naturally at 4 bits
   // An advance beats a pointer write in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_ptr_q <= '0;
         ex_ptr_q <= '0;
      end else begin
         if (rx_step) begin
            rx_ptr_q <= rx_ptr_q + 4'h1;
         end else if (ptr_wr && sel_lo) begin
            rx_ptr_q <= wb_dat_i[TTRM_PTR_RX_LSB +: TTRM_PTR_W];
         end
         if (ex_step) begin
            ex_ptr_q <= ex_ptr_q + 4'h1;
         end else if (ptr_wr && sel_hi) begin
            ex_ptr_q <= wb_dat_i[TTRM_PTR_EX_LSB +: TTRM_PTR_W];
         end
      end
   end

   // Control registers
   // Control bits 1:0 are kept for software but act on nothing here
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q    <= '0;
         irq_en_q  <= '0;
         port_en_q <= 1'b0;
      end else begin
         if (wr && hit_ctrl && sel_lo) begin
            ctrl_q <= wb_dat_i[TTRM_CTRL_W-1:0];
         end
         if (wr && hit_ien && sel_lo) begin
            irq_en_q <= wb_dat_i[TTRM_EV_N-1:0];
         end
         if (wr && hit_pen && sel_lo) begin
            port_en_q <= wb_dat_i[0];
         end
      end
   end

   // Read mux
   wire [7:0] rx_rd_byte = cur_q[rx_ptr_q*8 +: 8];
   wire [7:0] ex_rd_byte = exp_q[ex_ptr_q];
   logic [15:0] rd_val;
   always_comb begin
      rd_val = TTRM_RST_REG16;
      if (hit_ctrl) begin
         rd_val[TTRM_CTRL_W-1:0] = ctrl_q;
      end
      if (hit_ptr) begin
         rd_val[TTRM_PTR_RX_LSB +: TTRM_PTR_W] = rx_ptr_q;
         rd_val[TTRM_PTR_EX_LSB +: TTRM_PTR_W] = ex_ptr_q;
      end
      if (hit_live) begin
         rd_val[TTRM_EV_MISMATCH] = mism_q;
         rd_val[TTRM_EV_UNSTABLE] = live_unst;
         rd_val[TTRM_EV_IDLE]     = live_idle;
      end
      if (hit_lat) begin
         rd_val[TTRM_EV_N-1:0] = latch_q;
      end
      if (hit_ien) begin
         rd_val[TTRM_EV_N-1:0] = irq_en_q;
      end
      if (hit_pen) begin
         rd_val[0] = port_en_q;
      end
      if (hit_rxd) begin
         rd_val[7:0] = rx_rd_byte;
      end
      if (hit_exd) begin
         rd_val[7:0] = ex_rd_byte;
      end
   end

   // Bus answer; a request still held while ack is high is not taken again
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         if (rd) begin
            wb_dat_o <= {16'h0000, rd_val};
         end
      end
   end

   // Interrupt level from enabled sticky flags
   wire irq_d = port_en_q && |(latch_q & irq_en_q);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

endmodule : ttrm_top
`default_nettype wire

/* File: verification/ttrm_checker.sv */
// Port checker for the trace monitor: bus timing, read data, pointers, interrupt.
// Assumes it is bound into ttrm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ttrm_checker #(
   parameter int ADR_W  = 12,
   parameter int NBYTES = 16
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Wishbone
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [ADR_W-1:0]     wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   // Stream and interrupt
   input wire ttrm_pkg::ttrm_byte_s rx_byte,
   input wire logic                 irq
);
   import ttrm_pkg::*;
   logic       tk, hit;
   logic [7:0] ix;
   logic [3:0] rp_q, ep_q, qt_q;
   assign tk  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign hit = tk && wb_adr_i[11:10] == 2'h0;
   assign ix  = wb_adr_i[9:2];
   // Shadow pointers, moved by the same accesses as the design's
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rp_q <= 4'h0;
         ep_q <= 4'h0;
      end else if (hit) begin
         if (wb_we_i && ix == TTRM_IDX_PTR && wb_sel_i[0]) rp_q <= wb_dat_i[3:0];
         if (wb_we_i && ix == TTRM_IDX_PTR && wb_sel_i[1]) ep_q <= wb_dat_i[11:8];
         if (!wb_we_i && ix == TTRM_IDX_RX_DATA) rp_q <= rp_q + 4'h1;
         if (ix == TTRM_IDX_EX_DATA && (!wb_we_i || wb_sel_i[0])) ep_q <= ep_q + 4'h1;
      end
   end
   // Cycles since the last byte or register write
   always_ff @(posedge clk) begin
      if (sys_rst || rx_byte.valid || (tk && wb_we_i)) qt_q <= 4'h0;
      else if (qt_q != 4'hf) qt_q <= qt_q + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   ack_latency_a: assert property (tk |=> wb_ack_o) else $error("ack not one cycle after request");
   rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && !irq && wb_dat_o == 32'h0)
      else $error("outputs not cleared by reset");
   dat_hold_a: assert property (!(tk && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
   unmapped_rd_a: assert property (tk && !wb_we_i && !hit |=> wb_dat_o == 32'h0) else $error("unmapped read");
   live_rsvd_a: assert property (hit && !wb_we_i && ix == TTRM_IDX_LIVE |=> wb_dat_o[15:3] == 13'h0)
      else $error("live status spare bits set");
   ptr_track_a: assert property (hit && !wb_we_i && ix == TTRM_IDX_PTR |=>
      wb_dat_o[11:0] == {ep_q, 4'h0, rp_q}) else $error("pointer value wrong");
   irq_fall_a: assert property ($fell(irq) |-> $past(tk && wb_we_i, 2))
      else $error("interrupt dropped without a write");
   irq_cause_a: assert property ($rose(irq) |-> qt_q < 4'h8)
      else $error("interrupt rose without cause");
   cover property ($rose(irq));
   cover property (tk && !hit);
   cover property (hit && ix == TTRM_IDX_RX_DATA);
endmodule : ttrm_checker
bind ttrm_top ttrm_checker #(.ADR_W(ADR_W), .NBYTES(NBYTES)) chk_u (.clk(clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte(rx_byte), .irq(irq));
`default_nettype wire

/* File: verification/ttrm_framer_model.sv */
// Framer stand-in: sends one 16-byte identifier per request, byte 0 marked first.
// Assumes go is held until busy rises; slow puts random gaps between bytes.
`timescale 1ns/1ps
`default_nettype none
module ttrm_framer_model (
   // Clock, reset and request
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                go,
   input  wire logic [127:0]        id,
   input  wire logic                slow,
   // Byte stream
   output var ttrm_pkg::ttrm_byte_s rx_byte,
   output logic                     busy
);
   import ttrm_pkg::*;
   logic [127:0] sh_q;
   logic [3:0]   n_q;
   logic [1:0]   gap_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy    <= 1'b0;
         n_q     <= 4'h0;
         gap_q   <= 2'h0;
         rx_byte <= '0;
      end else if (busy && gap_q == 2'h0) begin
         rx_byte <= '{valid: 1'b1, first: n_q == 4'h0, data: sh_q[8*n_q +: 8]};
         n_q     <= n_q + 4'h1;
         busy    <= n_q != 4'hf;
         gap_q   <= slow ? 2'($urandom % 3) : 2'h0;
      end else begin
         // Idle line toggles rather than keep the last byte
         rx_byte <= '{valid: 1'b0, first: 1'b0, data: ~rx_byte.data};
         if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
         if (!busy && go) begin
            busy <= 1'b1;
            sh_q <= id;
         end
      end
   end
endmodule : ttrm_framer_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the trace monitor: registers, identifier memories, status, interrupt.
// Assumes the framer model drives rx_byte and the checker is bound into ttrm_top.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ttrm_pkg::*;
   logic         clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, slow = 1'b0;
   logic         ack, irq, busy;
   logic [11:0]  adr = '0;
   logic [3:0]   sel = 4'h3;
   logic [31:0]  wdat = '0, rdat, q;
   logic [127:0] gid = '0, ex, ida, t;
   logic [15:0]  cv [4] = '{16'h0, 16'h8, 16'hc, 16'h4};
   logic [15:0]  ie [4] = '{16'h0, 16'h4, 16'h4, 16'hb};
   logic         pe [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   ttrm_byte_s   rxb;
   int           errors = 0, cmp_count = 0, cyc_n = 0;

   ttrm_top dut_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .rx_byte(rxb), .irq(irq));
   ttrm_framer_model fr_u (.clk(clk), .sys_rst(sys_rst), .go(go), .id(gid), .slow(slow),
      .rx_byte(rxb), .busy(busy));

   function automatic logic [11:0] a(input logic [7:0] ix);
      return {2'h0, ix, 2'h0};
   endfunction : a
   function automatic logic [127:0] rnd();
      return {$urandom, $urandom, $urandom, $urandom};
   endfunction : rnd
   function automatic logic [31:0] live(input logic m, u, i);
      return {29'h0, m, u, i};
   endfunction : live
   task automatic chk(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [11:0] ad, input logic [15:0] d);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= {16'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [7:0] ix, input logic [31:0] e);
      wb(1'b0, a(ix), 16'h0);
      chk(q, e);
   endtask : rd
   task automatic send(input logic [127:0] id);
      int n;
      n = 0;
      gid <= id;
      go  <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1 && n < 99) begin
         @(posedge clk);
         n++;
      end
      if (n >= 99) errors++;
      repeat (8) @(posedge clk);
   endtask : send
   task automatic tdone(input string s);
      $display("test %s done, mismatches so far %0d", s, errors);
   endtask : tdone
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 30000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(38160));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(TTRM_IDX_LIVE, 32'h0);
      rd(TTRM_IDX_LATCH, 32'h0);
      rd(TTRM_IDX_IRQ_EN, 32'h0);
      rd(TTRM_IDX_RX_DATA, 32'h0);
      rd(TTRM_IDX_PTR, 32'h1);
      wb(1'b1, a(TTRM_IDX_LIVE), 16'hffff);
      rd(TTRM_IDX_LIVE, 32'h0);
      wb(1'b1, 12'hc00 | a(TTRM_IDX_IRQ_EN), 16'h000f);
      rd(TTRM_IDX_IRQ_EN, 32'h0);
      wb(1'b0, 12'h400 | a(TTRM_IDX_LIVE), 16'h0);
      chk(q, 32'h0);
      wb(1'b1, a(TTRM_IDX_PTR), 16'h0);
      tdone("reset");
      ex = rnd();
      for (int i = 0; i < 16; i++)
         wb(1'b1, a(TTRM_IDX_EX_DATA), {8'h0, ex[8*i +: 8]});
      rd(TTRM_IDX_PTR, 32'h0);
      for (int i = 0; i < 16; i++)
         rd(TTRM_IDX_EX_DATA, {24'h0, ex[8*i +: 8]});
      wb(1'b1, a(TTRM_IDX_PTR), 16'h0f00);
      rd(TTRM_IDX_EX_DATA, {24'h0, ex[127:120]});
      rd(TTRM_IDX_PTR, 32'h0);
      sel <= 4'h1;
      wb(1'b1, a(TTRM_IDX_PTR), 16'h0905);
      sel <= 4'h3;
      rd(TTRM_IDX_PTR, 32'h5);
      wb(1'b1, a(TTRM_IDX_PTR), 16'h0);
      tdone("expected memory");
      wb(1'b1, a(TTRM_IDX_PORT_EN), 16'h1);
      wb(1'b1, a(TTRM_IDX_IRQ_EN), 16'hf);
      wb(1'b1, a(TTRM_IDX_CTRL), 16'h4);
      repeat (3) @(posedge clk);
      rd(TTRM_IDX_LIVE, live(1'b1, 1'b0, 1'b0));
      rd(TTRM_IDX_LATCH, 32'h4);
      chk(irq, 32'h1);
      wb(1'b1, a(TTRM_IDX_LATCH), 16'hf);
      chk(irq, 32'h0);
      ida = rnd();
      send(ida);
      send(ida);
      rd(TTRM_IDX_LATCH, 32'h8);
      for (int i = 0; i < 16; i++)
         rd(TTRM_IDX_RX_DATA, {24'h0, ida[8*i +: 8]});
      rd(TTRM_IDX_PTR, 32'h0);
      wb(1'b1, a(TTRM_IDX_LATCH), 16'hf);
      send(ex);
      send(ex);
      rd(TTRM_IDX_LIVE, live(1'b0, 1'b0, 1'b0));
      rd(TTRM_IDX_LATCH, 32'h8);
      send(ida);
      send(ida);
      rd(TTRM_IDX_LATCH, 32'hc);
      wb(1'b1, a(TTRM_IDX_LATCH), 16'hf);
      foreach (cv[i]) begin
         wb(1'b1, a(TTRM_IDX_CTRL), cv[i]);
         rd(TTRM_IDX_CTRL, {16'h0, cv[i]});
         repeat (3) @(posedge clk);
         rd(TTRM_IDX_LIVE, live(cv[i] == 16'h4, 1'b0, 1'b0));
      end
      rd(TTRM_IDX_LATCH, 32'h4);
      foreach (ie[i]) begin
         wb(1'b1, a(TTRM_IDX_IRQ_EN), ie[i]);
         wb(1'b1, a(TTRM_IDX_PORT_EN), {15'h0, pe[i]});
         rd(TTRM_IDX_IRQ_EN, {16'h0, ie[i]});
         rd(TTRM_IDX_PORT_EN, {31'h0, pe[i]});
         chk(irq, {31'h0, ie[i][2] & pe[i]});
      end
      wb(1'b1, a(TTRM_IDX_LATCH), 16'h4);
      rd(TTRM_IDX_LATCH, 32'h0);
      wb(1'b1, a(TTRM_IDX_IRQ_EN), 16'hf);
      tdone("mismatch and interrupt");
      slow <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         for (int k = 1; k <= 8; k++) begin
            t = rnd();
            send(t);
            rd(TTRM_IDX_LIVE, live(1'b1, k == 8, 1'b0));
         end
         send(t);
         rd(TTRM_IDX_LIVE, live(1'b1, 1'b0, 1'b0));
         rd(TTRM_IDX_LATCH, 32'ha);
         wb(1'b1, a(TTRM_IDX_LATCH), 16'hf);
      end
      tdone("unstable");
      for (int r = 0; r < 2; r++) begin
         for (int k = 1; k <= 4 + r; k++) begin
            send('0);
            rd(TTRM_IDX_LIVE, live(1'b1, 1'b0, r == 1 && k == 5));
         end
         send(rnd());
         rd(TTRM_IDX_LIVE, live(1'b1, 1'b0, 1'b0));
      end
      tdone("idle");
      wb(1'b1, a(TTRM_IDX_CTRL), 16'h8);
      send(ida);
      send(ida);
      rd(TTRM_IDX_LIVE, live(1'b0, 1'b0, 1'b0));
      rd(TTRM_IDX_RX_DATA, {24'h0, ida[7:0]});
      rd(TTRM_IDX_LATCH, 32'h9);
      tdone("unaligned");
      finish_test();
   end
endmodule : tb
`default_nettype wire
